// file: rtl/pcsm_pkg.sv
// Behaviour
// R1: In Endpoint mode a configuration write to a physical function's power-allocation control register gives a one-cycle pulse.
// R2: Bit 0 of the power-allocation change output belongs to physical function 0, bit 1 to physical function 1.
// R3: The power-allocation change output stays low in Root Port mode.
// R4: The buffer flush/fill enable output mirrors the two-bit enable field of Device Control 2.
// R5: In Root Port mode a locally initiated bandwidth change sets its status bit and, if enabled, signals the interrupt.
// R6: In Root Port mode an autonomous bandwidth change sets its status bit and, if enabled, signals the interrupt.
// R7: In Root Port mode an equalization request sets its status bit and, if enabled, signals the interrupt.
// R8: The link event interrupt stays low in Endpoint mode.
// R9: Each physical-function hint requester enable bit mirrors bit 8 of that function's requester control register.
// R10: The physical-function steering-tag mode output holds function 0 on bits 2:0 and function 1 on bits 5:3.
// R11: Each virtual-function hint requester enable bit mirrors bit 8 of that function's requester control register.
// R12: The virtual-function steering-tag mode output packs three bits per function, function 0 lowest.
// R13: Mirrored outputs change on the clock edge after the write and read zero after reset.
package pcsm_pkg;
  localparam int N_PF = 2;
  localparam int N_VF = 6;
  localparam int N_FN = N_PF + N_VF;
  localparam int FN_W = 3;
  localparam int MODE_W = 3;
  localparam int DATA_W = 32;

  // Function index: 0..1 physical, 2..7 virtual
  localparam logic [FN_W-1:0] FN_PF0 = 3'h0;
  localparam logic [FN_W-1:0] FN_VF0 = 3'h2;

  // Register selects for a configuration write
  typedef enum logic [2:0] {
    SEL_DPA_CTL = 3'h0,
    SEL_DEV_CTL2 = 3'h1,
    SEL_LINK_CTL_STS = 3'h2,
    SEL_LINK_CTL3 = 3'h3,
    SEL_LINK_STS2 = 3'h4,
    SEL_TPH_REQ_CTL = 3'h5
  } pcsm_sel_type;

  // Field positions
  localparam int TPH_REQ_EN_BIT = 8;
  localparam int TPH_MODE_LSB = 0;
  localparam int OBFF_LSB = 13;
  localparam int OBFF_W = 2;
  localparam int BW_MGMT_IE_BIT = 10;
  localparam int AUTO_BW_IE_BIT = 11;
  localparam int BW_MGMT_ST_BIT = 30;
  localparam int AUTO_BW_ST_BIT = 31;
  localparam int EQ_IE_BIT = 1;
  localparam int EQ_REQ_ST_BIT = 5;

  // Reset values
  localparam logic [OBFF_W-1:0] OBFF_RST = 2'h0;
  localparam logic [N_FN-1:0] TPH_EN_RST = 8'h00;
  localparam logic [MODE_W-1:0] TPH_MODE_RST = 3'h0;
  localparam logic [N_PF-1:0] DPA_RST = 2'h0;
endpackage

// file: rtl/pcsm_tph_if.sv
`timescale 1ns/1ps
`default_nettype none
// Write path into the per-function hint register bank and its mirrored fields
interface pcsm_tph_if;
  import pcsm_pkg::*;
  logic wr;
  logic [FN_W-1:0] func;
  logic req_bit;
  logic [MODE_W-1:0] mode;
  logic [N_FN-1:0] on;
  logic [N_FN*MODE_W-1:0] mode_all;
  modport ctl (output wr, output func, output req_bit, output mode, input on, input mode_all);
  modport bank (input wr, input func, input req_bit, input mode, output on, output mode_all);
endinterface
`default_nettype wire

// file: rtl/pcsm_tph_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Per-function hint requester fields, one word per function, outputs straight from flops
module pcsm_tph_bank
  import pcsm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  pcsm_tph_if.bank tph
);
  logic [N_FN-1:0] on_r;
  logic [N_FN*MODE_W-1:0] mode_r;

  genvar i;
  generate
    for (i = 0; i < N_FN; i++) begin : g_fn
      // Only the addressed function takes the write
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          on_r[i] <= TPH_EN_RST[i]; // [R13]
          mode_r[i*MODE_W +: MODE_W] <= TPH_MODE_RST; // [R13]
        end else if (tph.wr && (tph.func == FN_W'(i))) begin
          on_r[i] <= tph.req_bit; // [R9] [R11]
          mode_r[i*MODE_W +: MODE_W] <= tph.mode; // [R10] [R12]
        end
      end
    end
  endgenerate

  assign tph.on = on_r;
  assign tph.mode_all = mode_r;

  a_bank_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
    tph.wr |=> (on_r[$past(tph.func)] == $past(tph.req_bit)))
    else $error("hint enable did not follow the write");
  a_bank_mode_lands: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
    tph.wr |=> (mode_r[$past(tph.func)*MODE_W +: MODE_W] == $past(tph.mode)))
    else $error("steering mode did not follow the write");
endmodule
`default_nettype wire

// file: rtl/pcsm_cfg_status_mirror.sv
`timescale 1ns/1ps
`default_nettype none
// Sideband mirror of configuration fields and link events towards user logic
module pcsm_cfg_status_mirror
  import pcsm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic root_port_mode,
  input wire logic cfg_wr,
  input wire logic [FN_W-1:0] cfg_wr_func,
  input wire logic [2:0] cfg_wr_sel,
  input wire logic [DATA_W-1:0] cfg_wr_data,
  input wire logic bw_mgmt_event,
  input wire logic auto_bw_event,
  input wire logic eq_request_event,
  output logic [N_PF-1:0] dpa_substate_change,
  output logic [OBFF_W-1:0] obff_enable,
  output logic link_event_interrupt,
  output logic link_event_irq_alias,
  output logic bw_mgmt_status,
  output logic auto_bw_status,
  output logic eq_request_status,
  output logic [N_PF-1:0] tph_requester_enable,
  output logic [N_PF*MODE_W-1:0] pf_steering_tag_mode,
  output logic [N_VF-1:0] vf_hint_requester_on,
  output logic [N_VF*MODE_W-1:0] vf_steering_tag_mode
);
  pcsm_tph_if tph ();

  // True for a write of the given register select
  function automatic logic wr_hit(input logic wr, input logic [2:0] sel, input pcsm_sel_type want);
    wr_hit = wr && (sel == want);
  endfunction

  // True when the function index names a physical function
  function automatic logic is_pf(input logic [FN_W-1:0] fn);
    is_pf = (fn < FN_VF0);
  endfunction

  logic dpa_wr;
  logic devctl2_wr;
  logic lnk_wr;
  logic lnk3_wr;
  logic sts2_wr;
  logic tph_wr;
  logic port_wr;
  logic [N_PF-1:0] dpa_change_r;
  logic [N_PF-1:0] dpa_change_nxt;
  logic [OBFF_W-1:0] obff_r;
  logic bw_ie_r;
  logic auto_ie_r;
  logic eq_ie_r;
  logic bw_st_r;
  logic bw_st_nxt;
  logic auto_st_r;
  logic auto_st_nxt;
  logic eq_st_r;
  logic eq_st_nxt;
  logic irq_r;
  logic irq_nxt;

  // Decode of the write strobe; link registers belong to the port itself, function 0
  assign port_wr = (cfg_wr_func == FN_PF0);
  assign dpa_wr = wr_hit(cfg_wr, cfg_wr_sel, SEL_DPA_CTL) && is_pf(cfg_wr_func);
  assign devctl2_wr = wr_hit(cfg_wr, cfg_wr_sel, SEL_DEV_CTL2) && port_wr;
  assign lnk_wr = wr_hit(cfg_wr, cfg_wr_sel, SEL_LINK_CTL_STS) && port_wr;
  assign lnk3_wr = wr_hit(cfg_wr, cfg_wr_sel, SEL_LINK_CTL3) && port_wr;
  assign sts2_wr = wr_hit(cfg_wr, cfg_wr_sel, SEL_LINK_STS2) && port_wr;
  assign tph_wr = wr_hit(cfg_wr, cfg_wr_sel, SEL_TPH_REQ_CTL);

  // Power-allocation change pulse, one bit per physical function
  always_comb begin
    dpa_change_nxt = '0;
    if (dpa_wr && !root_port_mode) begin // [R1] [R3]
      dpa_change_nxt[cfg_wr_func[0]] = 1'b1; // [R2]
    end
  end

  // Registered so that the pulse is exactly one clock wide
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dpa_change_r <= DPA_RST;
    end else begin
      dpa_change_r <= dpa_change_nxt; // [R1]
    end
  end

  // Device Control 2 flush/fill enable field
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      obff_r <= OBFF_RST; // [R13]
    end else if (devctl2_wr) begin
      obff_r <= cfg_wr_data[OBFF_LSB +: OBFF_W]; // [R4]
    end
  end

  // Interrupt enables of the link control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bw_ie_r <= 1'b0;
      auto_ie_r <= 1'b0;
      eq_ie_r <= 1'b0;
    end else begin
      if (lnk_wr) begin
        bw_ie_r <= cfg_wr_data[BW_MGMT_IE_BIT]; // [R5]
        auto_ie_r <= cfg_wr_data[AUTO_BW_IE_BIT]; // [R6]
      end
      if (lnk3_wr) begin
        eq_ie_r <= cfg_wr_data[EQ_IE_BIT]; // [R7]
      end
    end
  end

  // Sticky link status; write one clears, and a new event in the same cycle wins
  always_comb begin
    bw_st_nxt = bw_st_r & ~(lnk_wr & cfg_wr_data[BW_MGMT_ST_BIT]);
    auto_st_nxt = auto_st_r & ~(lnk_wr & cfg_wr_data[AUTO_BW_ST_BIT]);
    eq_st_nxt = eq_st_r & ~(sts2_wr & cfg_wr_data[EQ_REQ_ST_BIT]);
    if (root_port_mode && bw_mgmt_event) begin
      bw_st_nxt = 1'b1; // [R5]
    end
    if (root_port_mode && auto_bw_event) begin
      auto_st_nxt = 1'b1; // [R6]
    end
    if (root_port_mode && eq_request_event) begin
      eq_st_nxt = 1'b1; // [R7]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bw_st_r <= 1'b0;
      auto_st_r <= 1'b0;
      eq_st_r <= 1'b0;
    end else begin
      bw_st_r <= bw_st_nxt;
      auto_st_r <= auto_st_nxt;
      eq_st_r <= eq_st_nxt;
    end
  end

  // Interrupt pulse on an enabled event; Endpoint mode never signals
  always_comb begin
    irq_nxt = 1'b0;
    if (root_port_mode) begin // [R8]
      irq_nxt = (bw_mgmt_event && bw_ie_r) || // [R5]
                (auto_bw_event && auto_ie_r) || // [R6]
                (eq_request_event && eq_ie_r); // [R7]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Hint requester writes go to the per-function bank
  assign tph.wr = tph_wr;
  assign tph.func = cfg_wr_func;
  assign tph.req_bit = cfg_wr_data[TPH_REQ_EN_BIT]; // [R9] [R11]
  assign tph.mode = cfg_wr_data[TPH_MODE_LSB +: MODE_W];

  pcsm_tph_bank u_bank (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .tph (tph)
  );

  // Outputs; physical functions sit in the low slots of the bank
  assign dpa_substate_change = dpa_change_r;
  assign obff_enable = obff_r;
  assign link_event_interrupt = irq_r;
  assign link_event_irq_alias = irq_r;
  assign bw_mgmt_status = bw_st_r;
  assign auto_bw_status = auto_st_r;
  assign eq_request_status = eq_st_r;
  assign tph_requester_enable = tph.on[N_PF-1:0]; // [R9]
  assign pf_steering_tag_mode = tph.mode_all[N_PF*MODE_W-1:0]; // [R10]
  assign vf_hint_requester_on = tph.on[N_FN-1:N_PF]; // [R11]
  assign vf_steering_tag_mode = tph.mode_all[N_FN*MODE_W-1:N_PF*MODE_W]; // [R12]

  // Checks
  sequence s_dpa_write;
    dpa_wr && !root_port_mode;
  endsequence
  sequence s_dpa_pulse;
    (dpa_substate_change != '0) ##1 (dpa_substate_change == '0);
  endsequence

  a_dpa_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    s_dpa_write ##1 !dpa_wr |-> s_dpa_pulse)
    else $error("power-allocation pulse not one cycle");
  a_dpa_bit_map: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    s_dpa_write |=> dpa_substate_change[$past(cfg_wr_func[0])])
    else $error("power-allocation pulse on wrong function bit");
  a_dpa_rp_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    $past(root_port_mode) |-> (dpa_substate_change == '0))
    else $error("power-allocation pulse in Root Port mode");
  a_obff_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    devctl2_wr |=> (obff_enable == $past(cfg_wr_data[OBFF_LSB +: OBFF_W])))
    else $error("flush/fill enable did not follow Device Control 2");
  a_bw_irq: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    (root_port_mode && bw_mgmt_event && bw_ie_r) |=> (link_event_interrupt && bw_mgmt_status))
    else $error("bandwidth event missed");
  a_auto_irq: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    (root_port_mode && auto_bw_event && auto_ie_r) |=> (link_event_interrupt && auto_bw_status))
    else $error("autonomous bandwidth event missed");
  a_eq_status: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    (root_port_mode && eq_request_event) |=> eq_request_status)
    else $error("equalization request status not set");
  a_ep_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
    !$past(root_port_mode) |-> !link_event_interrupt)
    else $error("link interrupt in Endpoint mode");
  a_tph_pf_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    (tph_wr && cfg_wr_func == FN_PF0) |=> (pf_steering_tag_mode[MODE_W-1:0] == $past(tph.mode)))
    else $error("function 0 steering mode not mirrored");

  // Only a write in Endpoint mode may start a pulse
  a_dpa_needs_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    (dpa_substate_change != '0) |-> $past(dpa_wr && !root_port_mode))
    else $error("power-allocation pulse without a write");

  // A single write names a single function
  a_dpa_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    $onehot0(dpa_substate_change))
    else $error("power-allocation pulse on two functions");

  // Without a write the field must not drift
  a_obff_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    !devctl2_wr |=> $stable(obff_enable))
    else $error("flush/fill enable changed without a write");

  // Write one clears a status bit unless a new event lands in the same cycle
  a_bw_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    (lnk_wr && cfg_wr_data[BW_MGMT_ST_BIT] && !(root_port_mode && bw_mgmt_event)) |=> !bw_mgmt_status)
    else $error("bandwidth status not cleared");
  a_auto_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    (lnk_wr && cfg_wr_data[AUTO_BW_ST_BIT] && !(root_port_mode && auto_bw_event)) |=> !auto_bw_status)
    else $error("autonomous bandwidth status not cleared");
  a_eq_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    (sts2_wr && cfg_wr_data[EQ_REQ_ST_BIT] && !(root_port_mode && eq_request_event)) |=> !eq_request_status)
    else $error("equalization status not cleared");

  // Status must survive until software clears it, or a poll could miss the event
  a_bw_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    (bw_mgmt_status && !(lnk_wr && cfg_wr_data[BW_MGMT_ST_BIT])) |=> bw_mgmt_status)
    else $error("bandwidth status lost");
  a_auto_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    (auto_bw_status && !(lnk_wr && cfg_wr_data[AUTO_BW_ST_BIT])) |=> auto_bw_status)
    else $error("autonomous bandwidth status lost");
  a_eq_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    (eq_request_status && !(sts2_wr && cfg_wr_data[EQ_REQ_ST_BIT])) |=> eq_request_status)
    else $error("equalization status lost");

  // Enabled equalization request raises the interrupt and its status together
  sequence s_eq_enabled;
    root_port_mode && eq_request_event && eq_ie_r;
  endsequence
  a_eq_irq: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    s_eq_enabled |=> (link_event_interrupt && eq_request_status))
    else $error("equalization event missed");

  // A pulse with no enabled event behind it would be a spurious interrupt
  a_irq_has_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5] [R6] [R7]
    link_event_interrupt |-> $past(root_port_mode && ((bw_mgmt_event && bw_ie_r) ||
      (auto_bw_event && auto_ie_r) || (eq_request_event && eq_ie_r))))
    else $error("link interrupt without an enabled event");

  // Link events are a Root Port matter; an Endpoint never collects status
  a_ep_status_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5] [R6] [R7]
    (!root_port_mode && !bw_mgmt_status && !auto_bw_status && !eq_request_status) |=>
      !(bw_mgmt_status || auto_bw_status || eq_request_status))
    else $error("link status set in Endpoint mode");

  // Spot checks of the end slots of the bank as seen on the outputs
  a_pf0_enable: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    (tph_wr && cfg_wr_func == FN_PF0) |=> (tph_requester_enable[0] == $past(tph.req_bit)))
    else $error("function 0 hint enable not mirrored");
  a_pf1_enable: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    (tph_wr && cfg_wr_func == FN_W'(N_PF - 1)) |=> (tph_requester_enable[N_PF-1] == $past(tph.req_bit)))
    else $error("function 1 hint enable not mirrored");
  a_pf1_mode: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    (tph_wr && cfg_wr_func == FN_W'(N_PF - 1)) |=> (pf_steering_tag_mode[N_PF*MODE_W-1 -: MODE_W] == $past(tph.mode)))
    else $error("function 1 steering mode not mirrored");
  a_vf0_enable: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
    (tph_wr && cfg_wr_func == FN_VF0) |=> (vf_hint_requester_on[0] == $past(tph.req_bit)))
    else $error("virtual function 0 hint enable not mirrored");
  a_vf0_mode: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
    (tph_wr && cfg_wr_func == FN_VF0) |=> (vf_steering_tag_mode[MODE_W-1:0] == $past(tph.mode)))
    else $error("virtual function 0 steering mode not mirrored");
  a_vf5_enable: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
    (tph_wr && cfg_wr_func == FN_W'(N_FN - 1)) |=> (vf_hint_requester_on[N_VF-1] == $past(tph.req_bit)))
    else $error("last virtual function hint enable not mirrored");
  a_vf5_mode: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
    (tph_wr && cfg_wr_func == FN_W'(N_FN - 1)) |=> (vf_steering_tag_mode[N_VF*MODE_W-1 -: MODE_W] == $past(tph.mode)))
    else $error("last virtual function steering mode not mirrored");

  // Outputs must still read zero at the first edge after reset is released
  a_reset_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
    $rose(rst_n) |-> ((dpa_substate_change == '0) && (obff_enable == '0) && !link_event_interrupt &&
      (tph_requester_enable == '0) && (vf_hint_requester_on == '0)))
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// file: testbench/pcsm_user_model.sv
`timescale 1ns/1ps
`default_nettype none
// User-side handler that counts link event interrupt pulses as software would
module pcsm_user_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic irq,
  output logic [15:0] irq_cnt
);
  // An edge-detecting handler would miss back-to-back pulses, so count each cycle the line is high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_cnt <= 16'h0000;
    end else if (irq) begin
      irq_cnt <= irq_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcsm_pkg::*;
  typedef struct packed {logic [1:0] dpa; logic [1:0] obff; logic irq; logic [2:0] st; logic [7:0] en;
    logic [23:0] md;} pcsm_exp_type;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rp = 1'b0;
  logic wr = 1'b0;
  logic [2:0] fn = 3'h0;
  logic [2:0] sel = 3'h0;
  logic [31:0] dat = 32'h0;
  logic [2:0] ev = 3'h0;
  logic [1:0] dpa, obff, pf_en;
  logic irq, irq2;
  logic [2:0] st;
  logic [5:0] pf_md, vf_en;
  logic [17:0] vf_md;
  logic [15:0] irq_cnt;
  logic [2:0] ie = 3'h0;
  pcsm_exp_type e = '0;
  pcsm_exp_type x;
  pcsm_exp_type q[$];
  int n_fail = 0;
  int n_compared = 0;
  int n_irq = 0;

  always #12.5 ref_clk = ~ref_clk;

  pcsm_cfg_status_mirror DUT (.ref_clk(ref_clk), .rst_n(rst_n), .root_port_mode(rp), .cfg_wr(wr),
    .cfg_wr_func(fn), .cfg_wr_sel(sel), .cfg_wr_data(dat), .bw_mgmt_event(ev[0]), .auto_bw_event(ev[1]),
    .eq_request_event(ev[2]), .dpa_substate_change(dpa), .obff_enable(obff), .link_event_interrupt(irq),
    .link_event_irq_alias(irq2), .bw_mgmt_status(st[0]), .auto_bw_status(st[1]), .eq_request_status(st[2]),
    .tph_requester_enable(pf_en), .pf_steering_tag_mode(pf_md), .vf_hint_requester_on(vf_en),
    .vf_steering_tag_mode(vf_md));

  pcsm_user_model partner (.ref_clk(ref_clk), .rst_n(rst_n), .irq(irq), .irq_cnt(irq_cnt));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Drive one cycle off the sampling edge and note what the next edge must show
  task automatic step(input logic r, input logic w, input logic [2:0] f, input logic [2:0] s,
    input logic [31:0] d, input logic [2:0] v);
    @(negedge ref_clk);
    rst_n = r; wr = w; fn = f; sel = s; dat = d; ev = v;
    e.dpa = 2'h0;
    e.irq = 1'b0;
    if (!r) begin
      e = '0; ie = 3'h0; n_irq = 0;
    end else begin
      if (w && s == 3'h0 && f < 3'h2 && !rp) e.dpa[f[0]] = 1'b1;
      if (w && f == 3'h0 && s == 3'h1) e.obff = d[14:13];
      if (w && f == 3'h0 && s == 3'h2) begin
        ie[1:0] = d[11:10]; e.st[1:0] = e.st[1:0] & ~d[31:30];
      end
      if (w && f == 3'h0 && s == 3'h3) ie[2] = d[1];
      if (w && f == 3'h0 && s == 3'h4) e.st[2] = e.st[2] & ~d[5];
      if (w && s == 3'h5) begin
        e.en[f] = d[8]; e.md[3*f +: 3] = d[2:0];
      end
      // Set wins over a clear in the same cycle, so events are applied last
      if (rp) begin
        e.st = e.st | v; e.irq = |(v & ie); n_irq += e.irq;
      end
    end
    q.push_back(e);
  endtask

  // Reset, walk all flush/fill codes, then random traffic in one port mode
  task automatic run_phase(input logic mode);
    logic [2:0] f, s, v;
    logic w;
    @(negedge ref_clk);
    rp = mode;
    for (int i = 0; i < 16; i++) step(0, 0, 0, 0, 0, 0);
    for (int i = 0; i < 4; i++) step(1, 1, 3'h0, 3'h1, 32'(i) << 13, 3'h0);
    for (int i = 0; i < 400; i++) begin
      w = 1'($urandom_range(0, 1));
      s = 3'($urandom_range(0, 7));
      f = $urandom_range(0, 1) ? 3'h0 : 3'($urandom_range(0, 7));
      // Enable writes and events never share an edge, the order there is left open
      v = (w && (s == 3'h2 || s == 3'h3)) ? 3'h0 : 3'($urandom) & 3'($urandom);
      step(1, w, f, s, $urandom, v);
    end
    step(1, 0, 0, 0, 0, 0);
    @(posedge ref_clk);
    #2 chk(24'(irq_cnt), 24'(n_irq));
  endtask

  // Each settled cycle retires the oldest expectation
  always @(posedge ref_clk) begin
    #1;
    if (q.size() > 0) begin
      x = q.pop_front();
      chk(24'(dpa), 24'(x.dpa));
      chk(24'(obff), 24'(x.obff));
      chk(24'({irq2, irq}), 24'({2{x.irq}}));
      chk(24'(st), 24'(x.st));
      chk(24'({vf_en, pf_en}), 24'(x.en));
      chk({vf_md, pf_md}, x.md);
    end
  end

  task automatic summarize();
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'hDF1E7F3E));
    run_phase(1'b0);
    run_phase(1'b1);
    summarize();
  end

  // About 850 cycles are needed, so 2000 leaves ample margin
  initial begin
    #(2000 * 25);
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
